// ===== synth_pkg.sv
// Constants shared by the synthesizer control logic.
package synth_pkg;

   // -----------------------------------------------------------------
   // Serial word layout
   // -----------------------------------------------------------------
   localparam int SHIFT_WIDTH  = 11;
   localparam int SEL_BIT      = 10;
   localparam int LATCH_A_W    = 10;
   localparam int LATCH_B_W    = 8;
   localparam int N_FIELD_LSB  = 0;
   localparam int N_FIELD_W    = 5;
   localparam int DAC_LSB      = 5;
   localparam int DAC_W        = 5;
   localparam int M_FIELD_LSB  = 0;
   localparam int M_FIELD_W    = 8;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [LATCH_A_W-1:0]   LATCH_A_RESET = 10'h000;
   localparam logic [LATCH_B_W-1:0]   LATCH_B_RESET = 8'h00;
   localparam logic [SHIFT_WIDTH-1:0] SHIFT_RESET   = 11'h000;

   // -----------------------------------------------------------------
   // Output clock dividers
   // -----------------------------------------------------------------
   localparam logic [1:0] BYTE_DIV_WIDE   = 2'h2;  // Last phase of /3.
   localparam logic [1:0] PHASE_ZERO      = 2'h0;

endpackage : synth_pkg

// ===== synth_serial_prog_dividers.sv
// Serial programming port, N/M dividers, detector and output dividers.

// Behaviour
// - Reference clock divided by programmable 1..32 feeds detector reference.
// - Code clock divided by programmable 1..256 feeds detector variable input.
// - Reference pulse raises pump-up; variable pulse raises pump-down.
// - Both requests asserted resets both; minimum width one clock.
// - In lock both requests are asserted together for equal short time.
// - Pump-up and pump-down are shown on two test outputs.
// - Charge pump sources on pump-up and sinks on pump-down.
// - Code select 0: byte clock is oscillator/2, code clock equals oscillator.
// - Code select 1: byte clock is oscillator/3, code clock oscillator/2.
// - Five-bit converter code is driven in parallel from latch A.
// - Converter code is latch A bits 9..5, bit 9 most significant.
// - Eleven-bit shift chain takes data on serial clock rise while enable low.
// - Serial data and clock are ignored while load enable is high.
// - Latch A holds 10 bits, latch B holds 8 bits.
// - Load enable rise moves shift contents into exactly one latch.
// - Select bit low loads latch A, high loads latch B.
// - The latch not selected keeps its contents.
// - Latch A bits 4..0 set N; latch B bits 7..0 set M.
// - Divider ratio is field value plus one.
// - Fault output goes low when divider latch contents are corrupted.
// - Feedback select high uses internal divider, low the external input.
// - Detector enable low shuts the detector off.
module synth_serial_prog_dividers
   import synth_pkg::*;
(
   input  wire logic                 clk,                    // 50 MHz clock
   input  wire logic                 sys_rst,                // Sync reset
   input  wire logic                 serial_clock,           // Shift clock
   input  wire logic                 serial_in_bit,          // Shift data
   input  wire logic                 serial_load_enable_n,   // Load enable
   input  wire logic                 reference_clock_in,     // Reference
   input  wire logic                 oscillator_clock_in,    // Oscillator
   input  wire logic                 code_select,            // Code option
   input  wire logic                 feedback_source_select, // Feedback src
   input  wire logic                 external_detector_input,// Ext feedback
   input  wire logic                 detector_enable,        // Detector on
   output logic                      oscillator_clock_out,   // Osc copy
   output logic                      byte_rate_clock,        // Byte clock
   output logic                      code_rate_clock,        // Code clock
   output logic                      ref_div_out,            // N test out
   output logic                      fb_div_out,             // M test out
   output logic                      pump_up_test,           // Up test pin
   output logic                      pump_down_test,         // Down test pin
   output logic                      charge_pump_source,     // Source current
   output logic                      charge_pump_sink,       // Sink current
   output logic [DAC_W-1:0]          dac_code,               // Converter code
   output logic                      latch_fault_n           // Fault, low
);

   // ----------------------------------------------------------------
   // Edge detection of sampled inputs and of the code clock output
   // ----------------------------------------------------------------
   logic sclk_prev_reg, load_prev_reg, ref_prev_reg, osc_prev_reg;
   logic code_prev_reg, ext_prev_reg;
   logic sclk_rise, load_rise, ref_rise, osc_rise, code_rise, ext_rise;

   // A rise is a high sample that follows a low one.
   function automatic logic rise_of(input logic now_level,
                                    input logic last_level);
      return now_level & ~last_level;
   endfunction : rise_of

   // The serial pins reset to their idle levels, so a host that is already
   // idle at release does not look like a shift or load edge.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclk_prev_reg <= 1'b0;
      end else begin
         sclk_prev_reg <= serial_clock;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         load_prev_reg <= 1'b1;
      end else begin
         load_prev_reg <= serial_load_enable_n;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ref_prev_reg <= 1'b0;
      end else begin
         ref_prev_reg <= reference_clock_in;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         osc_prev_reg <= 1'b0;
      end else begin
         osc_prev_reg <= oscillator_clock_in;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         code_prev_reg <= 1'b0;
      end else begin
         code_prev_reg <= code_rate_clock;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ext_prev_reg <= 1'b0;
      end else begin
         ext_prev_reg <= external_detector_input;
      end
   end

   assign sclk_rise = rise_of(serial_clock, sclk_prev_reg);
   assign load_rise = rise_of(serial_load_enable_n, load_prev_reg);
   assign ref_rise  = rise_of(reference_clock_in, ref_prev_reg);
   assign osc_rise  = rise_of(oscillator_clock_in, osc_prev_reg);
   assign code_rise = rise_of(code_rate_clock, code_prev_reg);
   assign ext_rise  = rise_of(external_detector_input, ext_prev_reg);

   // ----------------------------------------------------------------
   // Serial shift chain
   // ----------------------------------------------------------------
   logic [SHIFT_WIDTH-1:0] shift_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shift_reg <= SHIFT_RESET;
      end else if (sclk_rise && !serial_load_enable_n) begin
         shift_reg <= {shift_reg[SHIFT_WIDTH-2:0], serial_in_bit};
      end
   end

   // ----------------------------------------------------------------
   // Parallel latches with complement shadows for fault detection
   // ----------------------------------------------------------------
   logic [LATCH_A_W-1:0] ref_div_and_dac_latch_reg, shadow_a_reg;
   logic [LATCH_B_W-1:0] feedback_div_latch_reg, shadow_b_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ref_div_and_dac_latch_reg <= LATCH_A_RESET;
         shadow_a_reg              <= ~LATCH_A_RESET;
      end else if (load_rise && !shift_reg[SEL_BIT]) begin
         ref_div_and_dac_latch_reg <= shift_reg[LATCH_A_W-1:0];
         shadow_a_reg              <= ~shift_reg[LATCH_A_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         feedback_div_latch_reg <= LATCH_B_RESET;
         shadow_b_reg           <= ~LATCH_B_RESET;
      end else if (load_rise && shift_reg[SEL_BIT]) begin
         feedback_div_latch_reg <= shift_reg[LATCH_B_W-1:0];
         shadow_b_reg           <= ~shift_reg[LATCH_B_W-1:0];
      end
   end

   // A latch whose shadow no longer holds its complement has been upset.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         latch_fault_n <= 1'b1;
      end else begin
         latch_fault_n <= &(ref_div_and_dac_latch_reg ^ shadow_a_reg) &
                          &(feedback_div_latch_reg ^ shadow_b_reg);
      end
   end

   assign dac_code =
      ref_div_and_dac_latch_reg[DAC_LSB +: DAC_W];

   // ----------------------------------------------------------------
   // Programmable dividers
   // ----------------------------------------------------------------
   logic [N_FIELD_W-1:0] n_field, n_count_reg;
   logic [M_FIELD_W-1:0] m_field, m_count_reg;

   assign n_field = ref_div_and_dac_latch_reg[N_FIELD_LSB +: N_FIELD_W];
   assign m_field = feedback_div_latch_reg[M_FIELD_LSB +: M_FIELD_W];

   // The compare is >= so that a field lowered mid-count still wraps at
   // once instead of running round the whole counter.
   function automatic logic div_wraps(input logic [M_FIELD_W-1:0] count,
                                      input logic [M_FIELD_W-1:0] field);
      return count >= field;
   endfunction : div_wraps

   logic n_wrap, m_wrap;

   assign n_wrap = div_wraps(M_FIELD_W'(n_count_reg), M_FIELD_W'(n_field));
   assign m_wrap = div_wraps(m_count_reg, m_field);

   // One output pulse per (field + 1) input edges; field 0 passes every edge.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         n_count_reg <= '0;
         ref_div_out <= 1'b0;
      end else begin
         ref_div_out <= 1'b0;
         if (ref_rise) begin
            if (n_wrap) begin
               n_count_reg <= '0;
               ref_div_out <= 1'b1;
            end else begin
               n_count_reg <= n_count_reg + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         m_count_reg <= '0;
         fb_div_out  <= 1'b0;
      end else begin
         fb_div_out <= 1'b0;
         if (code_rise) begin
            if (m_wrap) begin
               m_count_reg <= '0;
               fb_div_out  <= 1'b1;
            end else begin
               m_count_reg <= m_count_reg + 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Phase-frequency detector
   // ----------------------------------------------------------------
   logic var_pulse, up_reg, down_reg;

   assign var_pulse = feedback_source_select ? fb_div_out : ext_rise;

   // Both set in one cycle clears both in the next, so lock gives equal,
   // coincident one-cycle pulses.
   always_ff @(posedge clk) begin
      if (sys_rst || !detector_enable) begin
         up_reg <= 1'b0;
      end else if (up_reg && down_reg) begin
         up_reg <= 1'b0;
      end else begin
         up_reg <= up_reg | ref_div_out;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || !detector_enable) begin
         down_reg <= 1'b0;
      end else if (up_reg && down_reg) begin
         down_reg <= 1'b0;
      end else begin
         down_reg <= down_reg | var_pulse;
      end
   end

   assign pump_up_test       = up_reg;
   assign pump_down_test     = down_reg;
   assign charge_pump_source = up_reg;
   assign charge_pump_sink   = down_reg;

   // ----------------------------------------------------------------
   // Output clock dividers
   // ----------------------------------------------------------------
   logic [1:0] byte_phase_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         oscillator_clock_out <= 1'b0;
      end else begin
         oscillator_clock_out <= oscillator_clock_in;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         byte_phase_reg  <= PHASE_ZERO;
         byte_rate_clock <= 1'b0;
      end else if (osc_rise) begin
         if (!code_select) begin
            byte_phase_reg  <= PHASE_ZERO;
            byte_rate_clock <= ~byte_rate_clock;
         end else begin
            byte_phase_reg  <= (byte_phase_reg >= BYTE_DIV_WIDE) ?
                               PHASE_ZERO : byte_phase_reg + 1'b1;
            byte_rate_clock <= (byte_phase_reg == PHASE_ZERO);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         code_rate_clock <= 1'b0;
      end else if (!code_select) begin
         code_rate_clock <= oscillator_clock_in;
      end else if (osc_rise) begin
         code_rate_clock <= ~code_rate_clock;
      end
   end

endmodule : synth_serial_prog_dividers

// ===== host_serial_model.sv
// Host model that shifts words into the serial programming port.
module host_serial_model
   import synth_pkg::*;
(
   input  wire logic clk,                  // System clock
   output logic      serial_clock,         // Shift clock
   output logic      serial_in_bit,        // Shift data
   output logic      serial_load_enable_n  // Load enable, low
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      serial_clock = 1'b0;
      serial_in_bit = 1'b0;
      serial_load_enable_n = 1'b1;
   end

   task automatic pulse();
      @(posedge clk) serial_clock <= 1'b1;
      repeat (2) @(posedge clk);
      serial_clock <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : pulse

   task automatic send(input logic [SHIFT_WIDTH-1:0] word);
      @(posedge clk) serial_load_enable_n <= 1'b0;
      for (int i = SHIFT_WIDTH - 1; i >= 0; i--) begin
         serial_in_bit <= word[i];
         pulse();
      end
      serial_load_enable_n <= 1'b1;
      serial_in_bit <= ~word[0];
      repeat (3) @(posedge clk);
   endtask : send

   // Clocks zeros while disabled, then loads with no new bits shifted.
   task automatic noise();
      serial_in_bit <= 1'b0;
      repeat (3) pulse();
      serial_load_enable_n <= 1'b0;
      repeat (2) @(posedge clk);
      serial_load_enable_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : noise
endmodule : host_serial_model

// ===== synth_serial_prog_dividers_asserts.sv
// Concurrent checks on the synthesizer control block ports.
module synth_dividers_checker
   import synth_pkg::*;
(
   input wire logic             clk,                    // Clock
   input wire logic             sys_rst,                // Reset
   input wire logic             serial_load_enable_n,   // Load enable
   input wire logic             oscillator_clock_in,    // Oscillator
   input wire logic             code_select,            // Code option
   input wire logic             feedback_source_select, // Feedback src
   input wire logic             detector_enable,        // Detector on
   input wire logic             code_rate_clock,        // Code clock
   input wire logic             ref_div_out,            // N pulse
   input wire logic             fb_div_out,             // M pulse
   input wire logic             pump_up_test,           // Up request
   input wire logic             pump_down_test,         // Down request
   input wire logic             charge_pump_source,     // Source
   input wire logic             charge_pump_sink,       // Sink
   input wire logic [DAC_W-1:0] dac_code                // Converter code
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_pumps_held_off: assert property (
      !detector_enable |=> !pump_up_test && !pump_down_test)
      else $error("pump request while detector off");
   a_both_clear: assert property (
      pump_up_test && pump_down_test |=> !pump_up_test && !pump_down_test)
      else $error("pump requests not cleared together");
   a_up_cause: assert property (
      $rose(pump_up_test) |-> $past(ref_div_out))
      else $error("pump up without reference pulse");
   a_down_cause: assert property (
      $rose(pump_down_test) && $past(feedback_source_select)
      |-> $past(fb_div_out)) else $error("pump down without feedback");
   a_pump_pins: assert property (
      charge_pump_source == pump_up_test && charge_pump_sink == pump_down_test)
      else $error("pump pins differ from requests");
   a_code_follow: assert property (
      !code_select && !$past(code_select) && !$past(sys_rst)
      |-> code_rate_clock == $past(oscillator_clock_in))
      else $error("code clock not following oscillator");
   a_idle_no_load: assert property (
      serial_load_enable_n && $past(serial_load_enable_n) |=> $stable(dac_code))
      else $error("converter code changed while port idle");
   a_dac_on_load: assert property (
      $changed(dac_code) && !$past(sys_rst)
      |-> $past(serial_load_enable_n) && !$past(serial_load_enable_n, 2))
      else $error("converter code changed without load");
endmodule : synth_dividers_checker

bind synth_serial_prog_dividers synth_dividers_checker i_chk (
   .clk, .sys_rst, .serial_load_enable_n, .oscillator_clock_in, .code_select,
   .feedback_source_select, .detector_enable, .code_rate_clock, .ref_div_out,
   .fb_div_out, .pump_up_test, .pump_down_test, .charge_pump_source,
   .charge_pump_sink, .dac_code);

// ===== tb_synth_serial_prog_dividers.sv
// Self-checking bench for the synthesizer control block.
module tb_synth_serial_prog_dividers
   import synth_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0, sys_rst = 1'b1;
   logic reference_clock_in = 1'b0, oscillator_clock_in = 1'b1;
   logic external_detector_input = 1'b0, code_select = 1'b0;
   logic feedback_source_select = 1'b1, detector_enable = 1'b1;
   logic serial_clock, serial_in_bit, serial_load_enable_n;
   logic oscillator_clock_out, byte_rate_clock, code_rate_clock;
   logic ref_div_out, fb_div_out, pump_up_test, pump_down_test;
   logic charge_pump_source, charge_pump_sink, latch_fault_n;
   logic [DAC_W-1:0] dac_code;
   logic [15:0] p, q;
   int n_fail = 0, samples_checked = 0, cycles = 0;

   synth_serial_prog_dividers i_dut (
      .clk, .sys_rst, .serial_clock, .serial_in_bit, .serial_load_enable_n,
      .reference_clock_in, .oscillator_clock_in, .code_select,
      .feedback_source_select, .external_detector_input, .detector_enable,
      .oscillator_clock_out, .byte_rate_clock, .code_rate_clock, .ref_div_out,
      .fb_div_out, .pump_up_test, .pump_down_test, .charge_pump_source,
      .charge_pump_sink, .dac_code, .latch_fault_n);
   host_serial_model i_host (.clk, .serial_clock, .serial_in_bit,
      .serial_load_enable_n);

   always #10 clk = ~clk;

   always @(posedge clk) begin
      reference_clock_in <= ~reference_clock_in;
      oscillator_clock_in <= ~oscillator_clock_in;
      external_detector_input <= ~external_detector_input;
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Cycles between divider pulses, skipping the interval after a load.
   task automatic measure(input logic fb, output logic [15:0] n);
      n = 16'h0000;
      repeat (2) @(posedge clk iff (fb ? fb_div_out : ref_div_out));
      do begin
         @(posedge clk);
         n++;
      end while (!(fb ? fb_div_out : ref_div_out) && n < 16'h0800);
   endtask : measure

   function automatic logic out_clock(input logic code);
      return code ? code_rate_clock : byte_rate_clock;
   endfunction : out_clock

   // Cycles from one rise of an output clock to the next.
   task automatic clock_period(input logic code, output logic [15:0] n);
      n = 16'h0000;
      @(posedge clk iff !out_clock(code));
      @(posedge clk iff out_clock(code));
      do begin
         @(posedge clk);
         n++;
      end while (out_clock(code) && n < 16'h0100);
      do begin
         @(posedge clk);
         n++;
      end while (!out_clock(code) && n < 16'h0100);
   endtask : clock_period

   // Counts pump-up cycles seen on both its pins, and cycles in which the
   // two requests, or the down request and its sink pin, disagree.
   task automatic pump_watch(output logic [15:0] ups,
                             output logic [15:0] odd);
      ups = 16'h0000;
      odd = 16'h0000;
      repeat (20) begin
         @(posedge clk);
         if (pump_up_test && charge_pump_source)
            ups++;
         if (pump_up_test != pump_down_test ||
             charge_pump_sink != pump_down_test)
            odd++;
      end
   endtask : pump_watch

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      check("fault flag", 16'h0001, latch_fault_n);
      measure(1'b0, p);
      check("reset n period", 16'h0002, p);
      pump_watch(p, q);
      check("pump up cycles", 16'h000a, p);
      check("pump skew", 16'h0000, q);
      repeat (2) begin
         q = oscillator_clock_in;
         @(posedge clk);
         check("osc copy", q, oscillator_clock_out);
      end
      clock_period(1'b0, p);
      check("byte period", 16'h0004, p);
      clock_period(1'b1, p);
      check("code period", 16'h0002, p);
      i_host.send(11'h263);
      check("dac code", 16'h0013, dac_code);
      measure(1'b0, p);
      check("n period", 16'h0008, p);
      i_host.send(11'h3ff);
      check("dac max", 16'h001f, dac_code);
      measure(1'b0, p);
      check("n max period", 16'h0040, p);
      i_host.send(11'h4ff);
      check("dac kept", 16'h001f, dac_code);
      measure(1'b1, p);
      check("m max period", 16'h0200, p);
      i_host.send(11'h4a5);
      measure(1'b1, p);
      check("m period", 16'h014c, p);
      i_host.noise();
      measure(1'b1, p);
      check("m after idle clocks", 16'h014c, p);
      code_select <= 1'b1;
      measure(1'b1, p);
      check("m period code 1", 16'h0298, p);
      clock_period(1'b0, p);
      check("byte period code 1", 16'h0006, p);
      clock_period(1'b1, p);
      check("code period code 1", 16'h0004, p);
      detector_enable <= 1'b0;
      repeat (4) @(posedge clk);
      check("pumps off", 16'h0000, {pump_up_test, pump_down_test});
      feedback_source_select <= 1'b0;
      detector_enable <= 1'b1;
      q = 16'h0000;
      repeat (4) begin
         @(posedge clk);
         if (pump_down_test)
            q = 16'h0001;
      end
      check("down from external", 16'h0001, q);
      repeat (40) @(posedge clk);
      check("fault flag end", 16'h0001, latch_fault_n);
      end_of_test();
   end
endmodule : tb_synth_serial_prog_dividers
